// ==== mac_model.sv ====
// behavioural mac driving the transmit pins of the phy
`timescale 1ns/1ps
module mac_model (
	input  wire logic       go,     // hold high to send
	input  wire logic       mii,    // 1: mii levels, 0: rgmii double edge
	input  wire logic [3:0] nib,    // nibble to send
	input  wire logic       err,    // transmit error
	output logic            txc,    // rgmii transmit clock
	output logic            tx_ctl, // control line
	output logic      [3:0] txd     // data lines
);
	// idle: clock stands low, pulled-down lines read low
	initial begin
		txc = 1'b0;
		tx_ctl = 1'b0;
		txd = 4'h0;
	end
	////////////////////////////////////////
	// frames: the 160 ns clock runs only while go is high
	always begin
		wait (go);
		if (mii) begin
			tx_ctl = 1'b1;
			txd = nib;
			wait (!go);
		end else begin
			// start off the system clock edges so no pin moves in the step of a pclk edge during the frame; the release after it lands on a pclk edge
			#5;
			txd = nib;
			tx_ctl = 1'b1;
			#40 txc = 1'b1;
			#40 tx_ctl = 1'b1 ^ err;
			#40 txc = 1'b0;
			#35;
		end
		// released lines fall to their pull-downs
		if (!go) begin
			tx_ctl = 1'b0;
			txd = 4'h0;
		end
	end
endmodule

// ==== phy_mac_pins.sv ====
// mac-side pin functions: receive/transmit control, clocks, straps, indicator, apb
`timescale 1ns/1ps
module phy_mac_pins #(
	parameter int BLINK_CYCLES = phy_pin_pkg::BLINK_CYC  // blink half period in clocks
) (
	input  wire logic        pclk,              // system clock, 50 mhz
	input  wire logic        presetn,           // async reset, active low
	input  wire logic        psel,              // apb select
	input  wire logic        penable,           // apb access phase
	input  wire logic        pwrite,            // apb direction
	input  wire logic [7:0]  paddr,             // apb byte address
	input  wire logic [31:0] pwdata,            // apb write data
	output logic      [31:0] prdata,            // apb read data
	output logic             pready,            // apb ready
	output logic             pslverr,           // apb error on unmapped address
	input  wire logic        core_rx_valid,     // core: receive data valid
	input  wire logic        core_rx_error,     // core: receive error
	input  wire logic        core_carrier,      // core: carrier sense
	input  wire logic        core_collision,    // core: collision
	input  wire logic [3:0]  core_rxd,          // core: receive nibble
	input  wire logic        core_link_up,      // core: link established
	input  wire logic        core_activity,     // core: traffic pulse
	input  wire logic [1:0]  core_speed,        // core: speed code
	output logic             core_tx_en,        // to core: transmit enable
	output logic             core_tx_er,        // to core: transmit error
	output logic      [3:0]  core_txd,          // to core: transmit nibble
	output logic             rxc_out,           // receive clock pin out
	output logic             rxc_oe,            // receive clock pin enable
	input  wire logic        if_select_strap_lo,// receive clock pin in, strap
	output logic             rx_ctl_out,        // receive control pin out
	output logic             rx_ctl_oe,         // receive control pin enable
	input  wire logic        if_select_strap_hi,// receive control pin in, strap
	output logic      [3:0]  rxd_out,           // receive data pins
	input  wire logic        tx_ctl_in,         // transmit control pin from mac
	input  wire logic [3:0]  txd_in,            // transmit data pins from mac
	input  wire logic        txc_in,            // transmit clock pin in (rgmii)
	output logic             txc_out,           // transmit clock pin out (mii)
	output logic             txc_oe,            // transmit clock pin enable
	input  wire logic [1:0]  config_strap_a,    // indicator pin: four-level strap / tx error in
	output logic             activity_indicator_out, // indicator / collision pin out
	output logic             activity_indicator_oe,  // indicator pin enable
	input  wire logic [1:0]  config_strap_b,    // link pin four-level strap level
	output logic             link_up_out,       // link status pin
	input  wire logic [1:0]  crossover_mode_strap, // gp pin four-level strap level
	output logic             gen_purpose_clock_out, // gp clock / receive error pin
	output logic             gen_purpose_clock_oe   // gp pin enable
);
	import phy_pin_pkg::*;

	typedef struct packed {
		logic [7:0]  sync1, sync2, sync3;   // txc, tx_ctl, txd, tx_er
		logic [9:0]  str1, str2, str3;      // hi, lo, cfg_a, cfg_b, mdix
		logic        txc_level;
		phase_t      phase;
		logic [15:0] settle;
		if_mode_t    mode;
		logic [1:0]  cfg_a, cfg_b, mdix;
		logic        eee, led_low;
		logic [4:0]  ctrl;
		logic [7:0]  div;
		logic        rxc;
		logic        lat_valid, lat_err;
		logic [3:0]  lat_rxd;
		logic [31:0] blink;
		logic        blink_on, act_hold;
		logic [31:0] prdata;
		logic        pready, pslverr;
		logic        tx_en, tx_er;
		logic [3:0]  txd;
		logic        rxc_oe, rx_ctl, rx_ctl_oe, txc_oe, led, led_oe, link, gp, gp_oe;
		logic [3:0]  rxd;
	} state_t;

	state_t s, n;
	logic   txc_rise, txc_fall, stable, tog, rise_evt, fall_evt, run, led_lit, apb_wr;

	// half period of the generated receive/transmit clock for a speed code
	function automatic logic [7:0] half_cycles(input logic [1:0] spd);
		half_cycles = (spd == SPEED_1000) ? 8'(HALF_1000_CYC) :
			(spd == SPEED_100) ? 8'(HALF_100_CYC) : 8'(HALF_10_CYC);
	endfunction

	// four-level pin level to configuration value; level code is already binary
	function automatic logic [1:0] four_level(input logic [1:0] lvl);
		four_level = lvl;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb begin
		n = s;
		run = (s.phase == PH_RUN);
		// three-stage synchronisers for every pin input
		n.sync1 = {txc_in, tx_ctl_in, txd_in, config_strap_a[1], 1'b0};
		n.sync2 = s.sync1;
		n.sync3 = s.sync2;
		n.str1 = {if_select_strap_hi, if_select_strap_lo, config_strap_a,
			config_strap_b, crossover_mode_strap, 2'h0};
		n.str2 = s.str1;
		n.str3 = s.str2;
		// transmit clock edge only counts once stages two and three agree
		stable = (s.sync2[7] == s.sync3[7]);
		txc_rise = stable && s.sync3[7] && !s.txc_level;
		txc_fall = stable && !s.sync3[7] && s.txc_level;
		if (stable) begin
			n.txc_level = s.sync3[7];
		end

		// straps: hold pins released, wait for settle, then latch and drive
		if (s.phase == PH_STRAP) begin
			n.settle = s.settle + 16'h0001;
			if (s.settle >= 16'(STRAP_SETTLE_CYC) && s.str2 == s.str3) begin
				n.phase = PH_RUN;
				n.mode = !s.str3[9] ? IF_RGMII : (s.str3[8] ? IF_RMII : IF_MII);
				n.cfg_a = four_level(s.str3[7:6]);
				n.cfg_b = four_level(s.str3[5:4]);
				n.mdix = four_level(s.str3[3:2]);
				n.eee = s.str3[7];   // upper cfg_a levels advertise eee
				n.led_low = s.str3[7]; // pin pulled high at reset means led to supply
			end
		end

		// clock divider: one toggle enable per half period
		tog = run && (s.div >= half_cycles(core_speed) - 8'h01);
		n.div = tog ? 8'h00 : (run ? s.div + 8'h01 : 8'h00);
		rise_evt = tog && !s.rxc;
		fall_evt = tog && s.rxc;
		if (tog) begin
			n.rxc = !s.rxc;
		end

		// receive path
		n.rx_ctl_oe = run;
		n.rxc_oe = run && (s.mode != IF_RMII);
		n.txc_oe = run && (s.mode == IF_MII);
		unique case (s.mode)
			IF_RGMII: begin
				if (fall_evt) begin
					n.lat_valid = core_rx_valid;
					n.lat_err = core_rx_error;
					n.lat_rxd = core_rxd;
					n.rxd = core_rxd;
					n.rx_ctl = core_rx_valid;
				end else if (rise_evt) begin
					n.rx_ctl = s.lat_valid ^ s.lat_err;
				end
			end
			IF_MII: begin
				if (fall_evt) begin
					n.rxd = core_rxd;
					n.rx_ctl = core_rx_valid;
				end
			end
			IF_RMII: begin
				// reference clock is the system clock, a dibit each cycle
				n.rxd = {2'h0, core_rxd[1:0]};
				n.rx_ctl = core_carrier | core_rx_valid;
			end
			default: begin
				n.rx_ctl = 1'b0;
			end
		endcase

		// transmit path: rgmii on mac clock edges, mii on own clock rising edge
		if (s.mode == IF_RGMII && txc_rise) begin
			n.tx_en = s.sync3[6];
			n.txd = s.sync3[5:2];
		end else if (s.mode == IF_RGMII && txc_fall) begin
			n.tx_er = s.sync3[6] ^ s.tx_en;
		end else if (s.mode == IF_MII && rise_evt) begin
			n.tx_en = s.sync3[6];
			n.txd = s.sync3[5:2];
			n.tx_er = s.eee && s.sync3[1];
		end else if (s.mode == IF_RMII && run) begin
			n.tx_en = s.sync3[6];
			n.txd = {2'h0, s.sync3[3:2]};
			n.tx_er = 1'b0;
		end

		// indicator blink timer; activity holds blinking until the next blink toggle
		n.blink = (s.blink >= 32'(BLINK_CYCLES) - 32'h1) ? 32'h0 : s.blink + 32'h1;
		if (s.blink >= 32'(BLINK_CYCLES) - 32'h1) begin
			n.blink_on = !s.blink_on;
			n.act_hold = core_activity;
		end else if (core_activity) begin
			n.act_hold = 1'b1;
		end
		unique case (s.ctrl[CTRL_LED_MODE_LSB +: 2])
			LED_LINK_ACT: led_lit = core_link_up && !(s.act_hold && s.blink_on);
			LED_ON:       led_lit = 1'b1;
			LED_OFF:      led_lit = 1'b0;
			LED_LINK:     led_lit = core_link_up;
		endcase

		// shared indicator pin: led, collision or transmit error input
		if (s.mode == IF_MII && s.eee) begin
			n.led_oe = 1'b0;
			n.led = 1'b0;
		end else if (s.mode == IF_MII) begin
			n.led_oe = run;
			n.led = core_collision;
		end else begin
			n.led_oe = run;
			n.led = led_lit ^ s.led_low;
		end

		n.link = core_link_up ^ s.ctrl[CTRL_LINK_INV_BIT];

		// gp pin: receive error in mii/rmii, else optional clock output
		if (s.mode == IF_MII) begin
			n.gp_oe = run;
			n.gp = core_rx_error && (core_rx_valid || core_carrier);
		end else if (s.mode == IF_RMII) begin
			n.gp_oe = run;
			n.gp = core_rx_error;
		end else begin
			n.gp_oe = run && s.ctrl[CTRL_GP_EN_BIT];
			n.gp = s.ctrl[CTRL_GP_SEL_BIT] ? s.txc_level : s.rxc;
		end

		// apb: answer prepared in setup, ready in the first access cycle
		n.pready = psel && !penable;
		apb_wr = psel && penable && s.pready && pwrite;
		if (psel && !penable) begin
			n.pslverr = (paddr != CTRL_ADDR) && (paddr != STATUS_ADDR);
			n.prdata = 32'h0;
			if (paddr == CTRL_ADDR) begin
				n.prdata[4:0] = s.ctrl;
			end else if (paddr == STATUS_ADDR) begin
				n.prdata[ST_MODE_LSB +: 2] = s.mode;
				n.prdata[ST_CFG_A_LSB +: 2] = s.cfg_a;
				n.prdata[ST_CFG_B_LSB +: 2] = s.cfg_b;
				n.prdata[ST_MDIX_LSB +: 2] = s.mdix;
				n.prdata[ST_EEE_BIT] = s.eee;
				n.prdata[ST_LED_LOW_BIT] = s.led_low;
				n.prdata[ST_RUN_BIT] = run;
			end
		end
		if (apb_wr && paddr == CTRL_ADDR) begin
			n.ctrl = pwdata[4:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register; reset loads constants only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.phase <= PH_STRAP;
			s.mode <= IF_RGMII;
			s.ctrl <= CTRL_RESET;
		end else begin
			s <= n;
		end
	end

	// outputs straight from the state register
	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign core_tx_en = s.tx_en;
	assign core_tx_er = s.tx_er;
	assign core_txd = s.txd;
	assign rxc_out = s.rxc;
	assign rxc_oe = s.rxc_oe;
	assign rx_ctl_out = s.rx_ctl;
	assign rx_ctl_oe = s.rx_ctl_oe;
	assign rxd_out = s.rxd;
	assign txc_out = s.rxc;
	assign txc_oe = s.txc_oe;
	assign activity_indicator_out = s.led;
	assign activity_indicator_oe = s.led_oe;
	assign link_up_out = s.link;
	assign gen_purpose_clock_out = s.gp;
	assign gen_purpose_clock_oe = s.gp_oe;

	////////////////////////////////////////////////////////////////////////
	// checks
	rgmii_ctl_a: assert property (@(posedge pclk) disable iff (!presetn)
		(run && s.mode == IF_RGMII && rise_evt) |=> rx_ctl_out == $past(s.lat_valid ^ s.lat_err))
		else $error("rgmii second-edge control wrong");
	mii_valid_a: assert property (@(posedge pclk) disable iff (!presetn)
		(run && s.mode == IF_MII && fall_evt) |=> rx_ctl_out == $past(core_rx_valid))
		else $error("mii receive valid wrong");
	rmii_crsdv_a: assert property (@(posedge pclk) disable iff (!presetn)
		(run && s.mode == IF_RMII) |=> rx_ctl_out == $past(core_carrier | core_rx_valid))
		else $error("rmii carrier/valid wrong");
	mii_txclk_a: assert property (@(posedge pclk) disable iff (!presetn)
		(run && s.mode == IF_MII && tog) |=> txc_out != $past(txc_out) && txc_oe)
		else $error("mii transmit clock not toggling");
	mii_col_a: assert property (@(posedge pclk) disable iff (!presetn)
		(run && s.mode == IF_MII && !s.eee) |=> activity_indicator_out == $past(core_collision))
		else $error("collision output wrong");
	// the edge that releases reset still loads the reset value, so it is skipped
	link_pol_a: assert property (@(posedge pclk) disable iff (!presetn)
		$past(presetn) |-> link_up_out == $past(core_link_up ^ s.ctrl[CTRL_LINK_INV_BIT]))
		else $error("link status polarity wrong");
	mii_rxer_a: assert property (@(posedge pclk) disable iff (!presetn)
		(s.mode == IF_MII && gen_purpose_clock_out) |-> $past(core_rx_valid || core_carrier))
		else $error("receive error outside valid or carrier");
	strap_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(s.phase == PH_STRAP) |=> !rx_ctl_oe && !activity_indicator_oe && !gen_purpose_clock_oe)
		else $error("pin driven before straps latched");
	led_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		(run && s.mode != IF_MII && s.ctrl[1:0] == LED_LINK_ACT && !core_link_up)
		|=> activity_indicator_out == $past(s.led_low))
		else $error("indicator lit without link");
endmodule

// ==== phy_pin_pkg.sv ====
// shared constants and types for the mac-side pin function block
package phy_pin_pkg;
	// register map, apb byte addresses
	localparam logic [7:0] CTRL_ADDR      = 8'h00;
	localparam logic [7:0] STATUS_ADDR    = 8'h04;
	// control field positions
	localparam int CTRL_LED_MODE_LSB      = 0;
	localparam int CTRL_LINK_INV_BIT      = 2;
	localparam int CTRL_GP_EN_BIT         = 3;
	localparam int CTRL_GP_SEL_BIT        = 4;
	localparam logic [4:0] CTRL_RESET     = 5'h00;
	// status field positions
	localparam int ST_MODE_LSB            = 0;
	localparam int ST_CFG_A_LSB           = 2;
	localparam int ST_CFG_B_LSB           = 4;
	localparam int ST_MDIX_LSB            = 6;
	localparam int ST_EEE_BIT             = 8;
	localparam int ST_LED_LOW_BIT         = 9;
	localparam int ST_RUN_BIT             = 10;
	// indicator modes
	localparam logic [1:0] LED_LINK_ACT   = 2'h0;
	localparam logic [1:0] LED_ON         = 2'h1;
	localparam logic [1:0] LED_OFF        = 2'h2;
	localparam logic [1:0] LED_LINK       = 2'h3;
	// speed codes from the phy core
	localparam logic [1:0] SPEED_10       = 2'h0;
	localparam logic [1:0] SPEED_100      = 2'h1;
	localparam logic [1:0] SPEED_1000     = 2'h2;
	// clock half periods in picoseconds, and cycles of the 20 ns system clock
	localparam int CLK_PS                 = 20000;
	localparam int HALF_1000_PS           = 4000;
	localparam int HALF_100_PS            = 20000;
	localparam int HALF_10_PS             = 200000;
	localparam int HALF_1000_CYC = (HALF_1000_PS / CLK_PS < 1) ? 1 : HALF_1000_PS / CLK_PS;
	localparam int HALF_100_CYC  = (HALF_100_PS / CLK_PS < 1) ? 1 : HALF_100_PS / CLK_PS;
	localparam int HALF_10_CYC   = (HALF_10_PS / CLK_PS < 1) ? 1 : HALF_10_PS / CLK_PS;
	// strap settle time after reset release, and indicator blink half period
	localparam int STRAP_SETTLE_NS        = 200;
	localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int BLINK_MS               = 50;
	localparam int BLINK_CYC = BLINK_MS * 1000000 / (CLK_PS / 1000);
	typedef enum logic [1:0] {IF_RGMII, IF_MII, IF_RMII} if_mode_t;
	typedef enum logic {PH_STRAP, PH_RUN} phase_t;
endpackage

// ==== tb_phy_mac_pins.sv ====
// self-checking bench for the mac-side pin function block
`timescale 1ns/1ps
module tb_phy_mac_pins;
	import phy_pin_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [7:0]  paddr, obs;
	logic [31:0] pwdata, prdata, rd;
	logic        core_rx_valid, core_rx_error, core_carrier, core_collision, core_link_up;
	logic        core_activity, core_tx_en, core_tx_er, rxc_out, rxc_oe, rx_ctl_out, rx_ctl_oe;
	logic        tx_ctl_in, txc_in, txc_out, txc_oe, activity_indicator_out, activity_indicator_oe;
	logic        link_up_out, gen_purpose_clock_out, gen_purpose_clock_oe, hi_drv, lo_drv;
	logic        go, mii, err;
	logic [1:0]  core_speed, config_strap_a, config_strap_b, crossover_mode_strap;
	logic [3:0]  core_rxd, core_txd, rxd_out, txd_in, nib;
	int          fails, n_tests;
	// shared pins: the strap level shows only while the device is not driving
	wire         if_select_strap_hi = rx_ctl_oe ? rx_ctl_out : hi_drv;
	wire         if_select_strap_lo = rxc_oe ? rxc_out : lo_drv;
	assign obs = {activity_indicator_oe, txc_out, core_tx_er, core_tx_en,
		gen_purpose_clock_out, link_up_out, activity_indicator_out, rx_ctl_out};
	////////////////////////////////////////
	phy_mac_pins #(.BLINK_CYCLES(8)) phy_mac_pins_inst (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.core_rx_valid, .core_rx_error, .core_carrier, .core_collision, .core_rxd,
		.core_link_up, .core_activity, .core_speed, .core_tx_en, .core_tx_er, .core_txd,
		.rxc_out, .rxc_oe, .if_select_strap_lo, .rx_ctl_out, .rx_ctl_oe, .if_select_strap_hi,
		.rxd_out, .tx_ctl_in, .txd_in, .txc_in, .txc_out, .txc_oe, .config_strap_a,
		.activity_indicator_out, .activity_indicator_oe, .config_strap_b, .link_up_out,
		.crossover_mode_strap, .gen_purpose_clock_out, .gen_purpose_clock_oe);
	mac_model mac_model_inst (.go, .mii, .nib, .err, .txc(txc_in), .tx_ctl(tx_ctl_in), .txd(txd_in));
	always #10 pclk = ~pclk;
	////////////////////////////////////////
	task wrap_up();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// bounded wait for one observed pin; 400 cycles covers the slowest divider
	task wt(input int i, input logic v);
		for (int k = 0; k < 400; k++) begin
			@(posedge pclk);
			if (obs[i] === v) begin
				n_tests++;
				return;
			end
		end
		chk(32'(obs[i]), 32'(v));
		wrap_up();
	endtask
	// one apb transfer; the leading edge keeps psel from being driven twice in a step
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 50) begin
			chk(32'(pready), 32'h1);
			wrap_up();
		end
	endtask
	// reset with given straps, then read back what was latched
	task boot(input logic h, input logic l, input logic [1:0] a, input logic [1:0] md);
		@(posedge pclk);
		presetn <= 1'b0;
		{core_rx_valid, core_rx_error, core_carrier, core_collision, go} <= 5'h00;
		{hi_drv, lo_drv, config_strap_a} <= {h, l, a};
		{config_strap_b, crossover_mode_strap} <= {~a, a[0], a[1]};
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (20) @(posedge pclk);
		apb(1'b0, STATUS_ADDR, 32'h0);
		chk(rd, {21'h0, 1'b1, a[1], a[1], a[0], a[1], ~a, a, md});
		chk(32'({rx_ctl_oe, gen_purpose_clock_oe}), {30'h0, 1'b1, md != IF_RGMII});
	endtask
	////////////////////////////////////////
	task sc_rgmii();
		boot(1'b0, 1'b0, 2'h2, IF_RGMII);
		apb(1'b1, CTRL_ADDR, 32'(LED_ON));
		wt(1, 1'b0);
		apb(1'b1, CTRL_ADDR, 32'(LED_OFF));
		wt(1, 1'b1);
		core_link_up <= 1'b1;
		apb(1'b1, CTRL_ADDR, 32'h4);
		wt(2, 1'b0);
		apb(1'b1, CTRL_ADDR, 32'(LED_LINK_ACT));
		wt(2, 1'b1);
		wt(1, 1'b0);
		core_activity <= 1'b1;
		wt(1, 1'b1);
		wt(1, 1'b0);
		core_activity <= 1'b0;
		apb(1'b0, 8'h08, 32'h0);
		chk({rd[31:1], er}, 32'h1);
		core_rxd <= 4'h9;
		core_rx_valid <= 1'b1;
		wt(0, 1'b1);
		chk(32'(rxd_out), 32'h9);
		core_rx_error <= 1'b1;
		wt(0, 1'b0);
		wt(0, 1'b1);
		apb(1'b1, CTRL_ADDR, 32'h8);
		wt(3, 1'b1);
		wt(3, 1'b0);
		{nib, err, mii, go} <= {4'h5, 3'b001};
		wt(4, 1'b1);
		chk(32'(core_txd), 32'h5);
		err <= 1'b1;
		wt(5, 1'b1);
		go <= 1'b0;
	endtask
	task sc_mii();
		int k;
		boot(1'b1, 1'b0, 2'h1, IF_MII);
		core_rxd <= 4'hA;
		core_rx_valid <= 1'b1;
		wt(0, 1'b1);
		chk(32'(rxd_out), 32'hA);
		core_rx_error <= 1'b1;
		wt(3, 1'b1);
		core_rx_valid <= 1'b0;
		wt(0, 1'b0);
		wt(3, 1'b0);
		core_collision <= 1'b1;
		wt(1, 1'b1);
		core_collision <= 1'b0;
		wt(1, 1'b0);
		wt(6, 1'b1);
		wt(6, 1'b0);
		chk(32'(txc_oe), 32'h1);
		// slow speed: one low phase of the generated clock, counted in system cycles
		core_speed <= SPEED_10;
		wt(6, 1);
		wt(6, 0);
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (obs[6] !== 1'b1 && k < 400);
		chk(32'(k), 32'(HALF_10_CYC));
		core_speed <= SPEED_100;
		{nib, err, mii, go} <= {4'hC, 3'b011};
		wt(4, 1'b1);
		chk({core_txd, 3'h0, core_tx_er}, 32'hC0);
		go <= 1'b0;
		wt(4, 1'b0);
	endtask
	task sc_mii_eee();
		boot(1'b1, 1'b0, 2'h2, IF_MII);
		core_collision <= 1'b1;
		{nib, err, mii, go} <= {4'h3, 3'b011};
		wt(4, 1'b1);
		wt(5, 1'b1);
		chk(32'(activity_indicator_oe), 32'h0);
		go <= 1'b0;
	endtask
	task sc_rmii();
		boot(1'b1, 1'b1, 2'h0, IF_RMII);
		core_carrier <= 1'b1;
		wt(0, 1'b1);
		core_carrier <= 1'b0;
		wt(0, 1'b0);
		core_rx_valid <= 1'b1;
		wt(0, 1'b1);
		core_rx_error <= 1'b1;
		wt(3, 1'b1);
		chk(32'(rxc_oe), 32'h0);
	endtask
	////////////////////////////////////////
	initial begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata} <= '0;
		{core_rx_valid, core_rx_error, core_carrier, core_collision, core_link_up} <= '0;
		{core_activity, core_rxd, hi_drv, lo_drv, go, mii, err, nib} <= '0;
		{config_strap_a, config_strap_b, crossover_mode_strap} <= '0;
		core_speed <= SPEED_100;
		fails = 0;
		n_tests = 0;
		sc_rgmii();
		sc_mii();
		sc_mii_eee();
		sc_rmii();
		wrap_up();
	end
endmodule
